// ### src/spapm_pkg.sv
// package of constants for the serial port 0 and address pin mux
// assumes a single 100 MHz clock domain and an AHB-Lite register port
`default_nettype none
package spapm_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] spapm_ctrl_offset = 12'h000;
   localparam logic [15:0] spapm_ctrl_reset = 16'h0000;
   localparam int spapm_sp0_lsb = 8;
   localparam int spapm_a20_bit = 5;
   localparam int spapm_a19_bit = 4;
   localparam int spapm_a18_bit = 3;
   localparam logic [31:0] spapm_ctrl_wmask = 32'h0000_0338;
   // ****************************************
   // routing codes and bus codes
   // ****************************************
   localparam logic [1:0] spapm_route_card = 2'h0;
   localparam logic [1:0] spapm_route_audio = 2'h1;
   localparam logic [1:0] spapm_route_gpio = 2'h2;
   localparam logic [1:0] spapm_route_none = 2'h3;
   localparam logic [1:0] spapm_htrans_nonseq = 2'h2;
   localparam logic [1:0] spapm_htrans_seq = 2'h3;
endpackage : spapm_pkg
`default_nettype wire

// ### src/spapm_ctrl_if.sv
// interface carrying the pin-select fields from the register to the router
// assumes one clock domain; fields are registered at the source
`default_nettype none
interface spapm_ctrl_if;
   logic [1:0] serial_port0_route_sel;
   logic [2:0] addr_pin_sel;
   modport src (output serial_port0_route_sel, output addr_pin_sel);
   modport dst (input serial_port0_route_sel, input addr_pin_sel);
endinterface : spapm_ctrl_if
`default_nettype wire

// ### src/spapm_route.sv
// combinational pin router for serial port 0 and address lines 20..18
// assumes selects come from flip-flops in the register block
`default_nettype none
module spapm_route (
   spapm_ctrl_if.dst ctrl,
   input wire logic [5:0] card_out,
   input wire logic [5:0] card_oe,
   output logic [5:0] card_in,
   input wire logic [3:0] audio_out,
   input wire logic [3:0] audio_oe,
   output logic [3:0] audio_in,
   input wire logic [5:0] gp_low_out,
   input wire logic [5:0] gp_low_oe,
   output logic [5:0] gp_low_in,
   input wire logic [5:0] sp0_pin_in,
   output logic [5:0] sp0_pin_out,
   output logic [5:0] sp0_pin_oe,
   input wire logic [2:0] ext_mem_addr_hi,
   input wire logic [2:0] gp_hi_out,
   input wire logic [2:0] gp_hi_oe,
   output logic [2:0] gp_hi_in,
   input wire logic [2:0] addr_pin_in,
   output logic [2:0] addr_pin_out,
   output logic [2:0] addr_pin_oe
);
   // ****************************************
   // serial port 0 routing
   // ****************************************
   always_comb begin
      sp0_pin_out = 6'h00;
      sp0_pin_oe = 6'h00;
      card_in = 6'h00;
      audio_in = 4'h0;
      gp_low_in = 6'h00;
      case (ctrl.serial_port0_route_sel)
         spapm_pkg::spapm_route_card: begin
            sp0_pin_out = card_out;
            sp0_pin_oe = card_oe;
            card_in = sp0_pin_in;
         end
         spapm_pkg::spapm_route_audio: begin
            sp0_pin_out = {gp_low_out[5:4], audio_out};
            sp0_pin_oe = {gp_low_oe[5:4], audio_oe};
            audio_in = sp0_pin_in[3:0];
            gp_low_in = {sp0_pin_in[5:4], 4'h0};
         end
         spapm_pkg::spapm_route_gpio: begin
            sp0_pin_out = gp_low_out;
            sp0_pin_oe = gp_low_oe;
            gp_low_in = sp0_pin_in;
         end
         default: begin
            sp0_pin_out = 6'h00; // reserved code drives nothing
            sp0_pin_oe = 6'h00;
         end
      endcase
   end
   // ****************************************
   // address pins: index 2 is line 20, 0 is line 18
   // ****************************************
   always_comb begin
      gp_hi_in = 3'h0;
      addr_pin_out = 3'h0;
      addr_pin_oe = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (ctrl.addr_pin_sel[i]) begin
            addr_pin_out[i] = gp_hi_out[i];
            addr_pin_oe[i] = gp_hi_oe[i];
            gp_hi_in[i] = addr_pin_in[i];
         end else begin
            addr_pin_out[i] = ext_mem_addr_hi[i];
            addr_pin_oe[i] = 1'b1;
         end
      end
   end
endmodule : spapm_route
`default_nettype wire

// ### src/spapm_top.sv
// pin mux control: AHB-Lite register with serial port 0 and address pin selects
// assumes one clock hclk, asynchronous active-low reset, single-word transfers
// Functional notes
// - two-bit serial port 0 route select at bits 9:8; code 11 routes nothing.
// - code 00 connects all six memory-card signals to serial port 0 pins.
// - code 01 routes four audio serial signals plus general pins 5:4.
// - code 10 routes general pins 5:0 to serial port 0 pins.
// - bits 7:6 reserved, read zero, writes ignored.
// - bit 5 clear gives address line 20, set gives general pin 26.
// - bit 4 clear gives address line 19, set gives general pin 25.
// - bit 3 selects between address line 18 and general pin 24.
// - bit 3 clear gives address line 18, set gives general pin 24.
`default_nettype none
module spapm_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [5:0] memory_card_ctrl_inst0_out,
   input wire logic [5:0] memory_card_ctrl_inst0_oe,
   output logic [5:0] memory_card_ctrl_inst0_in,
   input wire logic [3:0] audio_serial_inst0_out,
   input wire logic [3:0] audio_serial_inst0_oe,
   output logic [3:0] audio_serial_inst0_in,
   input wire logic [5:0] general_pins_low_six_out,
   input wire logic [5:0] general_pins_low_six_oe,
   output logic [5:0] general_pins_low_six_in,
   input wire logic [5:0] sp0_pin_in,
   output logic [5:0] sp0_pin_out,
   output logic [5:0] sp0_pin_oe,
   input wire logic ext_mem_addr_line20,
   input wire logic ext_mem_addr_line19,
   input wire logic ext_mem_addr_line18,
   input wire logic [2:0] general_pin_26_24_out,
   input wire logic [2:0] general_pin_26_24_oe,
   output logic [2:0] general_pin_26_24_in,
   input wire logic [2:0] addr_pin_in,
   output logic [2:0] addr_pin_out,
   output logic [2:0] addr_pin_oe
);
   // ****************************************
   // control register fields
   // ****************************************
   logic [1:0] serial_port0_route_sel;
   logic addr20_pin_sel;
   logic addr19_pin_sel;
   logic addr18_pin_sel;
   logic wr_pend;
   logic [11:0] wr_addr;
   logic access;
   logic [31:0] ctrl_word;
   spapm_ctrl_if ctrl ();

   assign access = hsel & hready & (htrans == spapm_pkg::spapm_htrans_nonseq |
                                    htrans == spapm_pkg::spapm_htrans_seq);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // bus address phase capture
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= access & hwrite;
         wr_addr <= haddr[11:0];
      end
   end

   // ****************************************
   // register write in data phase
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_port0_route_sel <= spapm_pkg::spapm_ctrl_reset[9:8];
         addr20_pin_sel <= spapm_pkg::spapm_ctrl_reset[5];
         addr19_pin_sel <= spapm_pkg::spapm_ctrl_reset[4];
         addr18_pin_sel <= spapm_pkg::spapm_ctrl_reset[3];
      end else if (wr_pend && wr_addr == spapm_pkg::spapm_ctrl_offset) begin
         serial_port0_route_sel <= hwdata[spapm_pkg::spapm_sp0_lsb +: 2];
         addr20_pin_sel <= hwdata[spapm_pkg::spapm_a20_bit];
         addr19_pin_sel <= hwdata[spapm_pkg::spapm_a19_bit];
         addr18_pin_sel <= hwdata[spapm_pkg::spapm_a18_bit];
      end
   end

   // ****************************************
   // read data, registered at address phase
   // ****************************************
   always_comb begin
      ctrl_word = 32'h0000_0000; // reserved bits read zero
      ctrl_word[spapm_pkg::spapm_sp0_lsb +: 2] = serial_port0_route_sel;
      ctrl_word[spapm_pkg::spapm_a20_bit] = addr20_pin_sel;
      ctrl_word[spapm_pkg::spapm_a19_bit] = addr19_pin_sel;
      ctrl_word[spapm_pkg::spapm_a18_bit] = addr18_pin_sel;
      // a read right behind a write sees the word that the write is landing
      if (wr_pend && wr_addr == spapm_pkg::spapm_ctrl_offset) begin
         ctrl_word = hwdata & spapm_pkg::spapm_ctrl_wmask;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (access && !hwrite) begin
         if (haddr[11:0] == spapm_pkg::spapm_ctrl_offset && haddr[31:12] == 20'h0_0000) begin
            hrdata <= ctrl_word & spapm_pkg::spapm_ctrl_wmask;
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   assign ctrl.serial_port0_route_sel = serial_port0_route_sel;
   assign ctrl.addr_pin_sel = {addr20_pin_sel, addr19_pin_sel, addr18_pin_sel};

   // ****************************************
   // pin router
   // ****************************************
   spapm_route u_route (
      .ctrl(ctrl.dst),
      .card_out(memory_card_ctrl_inst0_out),
      .card_oe(memory_card_ctrl_inst0_oe),
      .card_in(memory_card_ctrl_inst0_in),
      .audio_out(audio_serial_inst0_out),
      .audio_oe(audio_serial_inst0_oe),
      .audio_in(audio_serial_inst0_in),
      .gp_low_out(general_pins_low_six_out),
      .gp_low_oe(general_pins_low_six_oe),
      .gp_low_in(general_pins_low_six_in),
      .sp0_pin_in(sp0_pin_in),
      .sp0_pin_out(sp0_pin_out),
      .sp0_pin_oe(sp0_pin_oe),
      .ext_mem_addr_hi({ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18}),
      .gp_hi_out(general_pin_26_24_out),
      .gp_hi_oe(general_pin_26_24_oe),
      .gp_hi_in(general_pin_26_24_in),
      .addr_pin_in(addr_pin_in),
      .addr_pin_out(addr_pin_out),
      .addr_pin_oe(addr_pin_oe)
   );
endmodule : spapm_top
`default_nettype wire

// ### bench/spapm_top_props.sv
// checker for the pin mux control block
// assumes it is bound into spapm_top with one clock hclk
`default_nettype none
module spapm_top_props (
   input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [5:0] memory_card_ctrl_inst0_out, memory_card_ctrl_inst0_oe,
   input wire logic [5:0] general_pins_low_six_out, general_pins_low_six_oe, sp0_pin_out, sp0_pin_oe,
   input wire logic [3:0] audio_serial_inst0_out, audio_serial_inst0_oe,
   input wire logic ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18,
   input wire logic [2:0] general_pin_26_24_out, general_pin_26_24_oe, addr_pin_out, addr_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // shadow of the select fields
   // ****************************************
   logic wp;
   logic rp;
   logic [9:0] sh;
   logic [2:0] em;
   assign em = {ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0;
         rp <= 1'b0;
         sh <= 10'h000;
      end else begin
         rp <= hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_0000;
         wp <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
         if (wp) sh <= hwdata[9:0] & 10'h338;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_card;
      sh[9:8] == 2'h0 |-> {sp0_pin_out, sp0_pin_oe} == {memory_card_ctrl_inst0_out, memory_card_ctrl_inst0_oe};
   endproperty
   property p_audio;
      sh[9:8] == 2'h1 |-> sp0_pin_out == {general_pins_low_six_out[5:4], audio_serial_inst0_out}
         && sp0_pin_oe == {general_pins_low_six_oe[5:4], audio_serial_inst0_oe};
   endproperty
   property p_gpio;
      sh[9:8] == 2'h2 |-> {sp0_pin_out, sp0_pin_oe} == {general_pins_low_six_out, general_pins_low_six_oe};
   endproperty
   property p_none;
      sh[9:8] == 2'h3 |-> sp0_pin_oe == 6'h00;
   endproperty
   property p_rsv;
      hrdata[7:6] == 2'h0 && hrdata[31:10] == 22'h00_0000 && hrdata[2:0] == 3'h0;
   endproperty
   property p_rdata;
      rp |-> hrdata == {22'h00_0000, sh};
   endproperty
   property p_pin(int i);
      sh[3 + i] ? addr_pin_out[i] == general_pin_26_24_out[i] && addr_pin_oe[i] == general_pin_26_24_oe[i]
         : addr_pin_out[i] == em[i] && addr_pin_oe[i];
   endproperty
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_card: assert property (p_card) else $error("card routing wrong");
   a_audio: assert property (p_audio) else $error("audio routing wrong");
   a_gpio: assert property (p_gpio) else $error("gpio routing wrong");
   a_none: assert property (p_none) else $error("code 11 drives pins");
   a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
   a_rdata: assert property (p_rdata) else $error("control read data wrong");
   a_pin20: assert property (p_pin(2)) else $error("line 20 pin wrong");
   a_pin19: assert property (p_pin(1)) else $error("line 19 pin wrong");
   a_pin18: assert property (p_pin(0)) else $error("line 18 pin wrong");
   a_okay: assert property (p_okay) else $error("bus answer not ready okay");
   c_audio: cover property (sh[9:8] == 2'h1);
   c_none: cover property (sh[9:8] == 2'h3);
   c_gp: cover property (sh[5:3] == 3'h7);
endmodule : spapm_top_props
bind spapm_top spapm_top_props i_props (.*);
`default_nettype wire

// ### bench/spapm_pins.sv
// far side of the shared pins: drives them whenever the chip does not
// assumes oe high means the chip drives the pin
`default_nettype none
module spapm_pins (
   input wire logic hclk,
   input wire logic [5:0] sp0_pin_out, sp0_pin_oe,
   input wire logic [2:0] addr_pin_out, addr_pin_oe,
   output logic [5:0] sp0_pin_in,
   output logic [2:0] addr_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] far = 6'h15;
   always @(posedge hclk) far <= far + 6'h1b;
   assign sp0_pin_in = (sp0_pin_out & sp0_pin_oe) | (far & ~sp0_pin_oe);
   assign addr_pin_in = (addr_pin_out & addr_pin_oe) | (far[2:0] & ~addr_pin_oe);
endmodule : spapm_pins
`default_nettype wire

// ### bench/serial_port_and_address_pin_mux_test.sv
// testbench of the pin mux control block with a behavioural register model
// assumes spapm_top, spapm_pins and the bound checker are compiled first
`default_nettype none
module serial_port_and_address_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [63:0] rnd = 0;
   logic [5:0] memory_card_ctrl_inst0_out, memory_card_ctrl_inst0_oe, memory_card_ctrl_inst0_in;
   logic [5:0] general_pins_low_six_out, general_pins_low_six_oe, general_pins_low_six_in;
   logic [5:0] sp0_pin_in, sp0_pin_out, sp0_pin_oe;
   logic [3:0] audio_serial_inst0_out, audio_serial_inst0_oe, audio_serial_inst0_in;
   logic [2:0] general_pin_26_24_out, general_pin_26_24_oe, general_pin_26_24_in, addr_pin_in, addr_pin_out, addr_pin_oe;
   logic ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18;
   int err_total = 0, num_checks = 0, seed = 84, sh = 0, r, i;
   assign {memory_card_ctrl_inst0_out, memory_card_ctrl_inst0_oe, audio_serial_inst0_out, audio_serial_inst0_oe,
      general_pins_low_six_out, general_pins_low_six_oe, general_pin_26_24_out, general_pin_26_24_oe,
      ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18} = rnd[40:0];
   spapm_top i_dut (.hready(hreadyout), .*);
   spapm_pins i_pins (.*);
   always #5 hclk = ~hclk;
   always @(posedge hclk) rnd <= {$random(seed), $random(seed)};
   task check(string nm, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task xfer(logic w, logic [31:0] a, logic [31:0] d);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      if (w && a[11:0] == 12'h000) sh = d & 32'h0000_0338;
      if (!w) check("ctrl read", q, a == 0 ? sh : 0);
   endtask : xfer
   task chk_pins;
      logic [5:0] eo, ee, ep;
      logic [2:0] em;
      r = (sh >> 8) & 3;
      em = {ext_mem_addr_line20, ext_mem_addr_line19, ext_mem_addr_line18};
      ep = {general_pins_low_six_out[5:4], audio_serial_inst0_out};
      eo = r == 0 ? memory_card_ctrl_inst0_out : r == 1 ? ep : r == 2 ? general_pins_low_six_out : 6'h00;
      ep = {general_pins_low_six_oe[5:4], audio_serial_inst0_oe};
      ee = r == 0 ? memory_card_ctrl_inst0_oe : r == 1 ? ep : r == 2 ? general_pins_low_six_oe : 6'h00;
      check("sp0 out", sp0_pin_out, eo);
      check("sp0 oe", sp0_pin_oe, ee);
      check("card in", memory_card_ctrl_inst0_in, r == 0 ? sp0_pin_in : 0);
      check("audio in", audio_serial_inst0_in, r == 1 ? sp0_pin_in[3:0] : 0);
      check("gp in", general_pins_low_six_in, r == 2 ? sp0_pin_in : r == 1 ? sp0_pin_in & 6'h30 : 0);
      for (int k = 0; k < 3; k++) begin
         ee[0] = (sh >> (3 + k)) & 1;
         check("addr out", addr_pin_out[k], ee[0] ? general_pin_26_24_out[k] : em[k]);
         check("addr oe", addr_pin_oe[k], ee[0] ? general_pin_26_24_oe[k] : 1'b1);
         check("gp hi in", general_pin_26_24_in[k], ee[0] ? addr_pin_in[k] : 1'b0);
      end
   endtask : chk_pins
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      xfer(0, 0, 0);
      @(negedge hclk) chk_pins();
      $display("test reset done");
      @(posedge hclk);
      for (i = 0; i < 40; i++) begin
         q = $random(seed);
         q[9:8] = i[1:0];
         xfer(1, 0, q);
         @(negedge hclk) chk_pins();
         @(posedge hclk) xfer(0, 0, 0);
         repeat (2) @(negedge hclk) chk_pins();
         @(posedge hclk);
      end
      $display("test routing done");
      xfer(1, 32'h0000_0004, 32'hffff_ffff);
      xfer(0, 32'h0000_0004, 0);
      xfer(0, 0, 0);
      @(negedge hclk) chk_pins();
      $display("test unmapped done");
      xfer(1, 0, 32'h0000_0338);
      @(negedge hclk) chk_pins();
      @(posedge hclk) hresetn <= 0;
      sh = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      @(negedge hclk) chk_pins();
      @(posedge hclk) xfer(0, 0, 0);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule : serial_port_and_address_pin_mux_test
`default_nettype wire
